// >>> src/vip_defines.svh
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH

`define VIP_NUM_TRAP      8
`define VIP_NUM_USER      80
`define VIP_FLAG_W        96
`define VIP_WORDS         3
`define VIP_WORD_W        32
`define VIP_PRIO_PER_REG  8
`define VIP_PRIO_FLD_W    4
`define VIP_PRIO_REGS     4'hA
`define VIP_IVT_BASE      24'h000004
`define VIP_ALTERNATE_VECTOR_TABLE_OFS      24'h000100
`define VIP_RESET_PC      24'h000000
`define VIP_USER_VEC0     7'h08
`define VIP_TRAP_LVL_TOP  4'hF
`define VIP_TRAP_IMPL     8'h3E
`define VIP_USER_IMPL     96'h0000_0000_CE7E_E600_601F_FFDF_7FFF
`define VIP_ALT_BIT       15
`define VIP_PEND_LVL_LSB  8
`define VIP_LVL_SW_W      3
`define VIP_OFS_CTRL2     8'h00
`define VIP_OFS_LEVEL     8'h04
`define VIP_OFS_TRAPF     8'h08
`define VIP_OFS_PEND      8'h0C
`define VIP_OFS_FLAG0     8'h10
`define VIP_OFS_EN0       8'h1C
`define VIP_PRIO_SEL      2'b01
`define VIP_OFS_STAT      8'h80
`define VIP_OFS_MASK      8'h84
`define VIP_EV_W          3
`define VIP_EV_USER       0
`define VIP_EV_TRAP       1
`define VIP_EV_RET        2

`endif

// >>> src/vip_pkg.sv
`include "vip_defines.svh"
package vip_pkg;
  typedef enum logic [2:0] {
    VIP_IDLE   = 3'b000,
    VIP_LATCH  = 3'b001,
    VIP_REQ    = 3'b010,
    VIP_SERVE  = 3'b011,
    VIP_RETURN = 3'b100
  } vip_state_t;
  typedef logic [2:0] vip_prio_t;
  typedef vip_prio_t [`VIP_NUM_USER-1:0] vip_prio_arr_t;
endpackage

// >>> src/vip_arb_if.sv
`timescale 1ns/1ps
`include "vip_defines.svh"
interface vip_arb_if;
  import vip_pkg::*;
  logic [`VIP_NUM_TRAP-1:0] trap_pend;
  logic [`VIP_NUM_USER-1:0] user_pend;
  vip_prio_arr_t            prio;
  logic                     win_valid;
  logic [6:0]               win_vec;
  logic [3:0]               win_lvl;
  modport arb (input trap_pend, user_pend, prio, output win_valid, win_vec, win_lvl);
  modport ctl (output trap_pend, user_pend, prio, input win_valid, win_vec, win_lvl);
endinterface

// >>> src/vip_arbiter.sv
`timescale 1ns/1ps
`include "vip_defines.svh"
module vip_arbiter (
  vip_arb_if.arb arb
);
  import vip_pkg::*;

  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_vec   = 7'h00;
    arb.win_lvl   = 4'h0;
    // scan downward so a lower position wins a tie.
    for (int i = `VIP_NUM_USER - 1; i >= 0; i--) begin
      if (arb.user_pend[i] && (!arb.win_valid || {1'b0, arb.prio[i]} >= arb.win_lvl)) begin
        arb.win_valid = 1'b1;
        arb.win_vec   = `VIP_USER_VEC0 + 7'(i);
        arb.win_lvl   = {1'b0, arb.prio[i]};
      end
    end
    // traps outrank: trap levels sit above every user level.
    for (int i = `VIP_NUM_TRAP - 1; i >= 0; i--) begin
      if (arb.trap_pend[i]) begin
        arb.win_valid = 1'b1;
        arb.win_vec   = 7'(i);
        arb.win_lvl   = `VIP_TRAP_LVL_TOP - 4'(i);
      end
    end
  end
endmodule // vip_arbiter

// >>> src/vip_controller.sv
`timescale 1ns/1ps
`include "vip_defines.svh"
module vip_controller (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [7:0]  trap_src_in,
  input  wire logic [79:0] user_src_in,
  input  wire logic        cpu_ack_in,
  input  wire logic        cpu_return_in,
  output logic             cpu_irq_req_out,
  output logic      [23:0] vector_addr_out,
  output logic      [3:0]  cpu_priority_level_out,
  output logic             irq_out
);
  import vip_pkg::*;

  vip_arb_if arb_bus ();

  vip_state_t                state_q;
  logic                      alt_table_select_q;
  logic [3:0]                cpu_priority_level_q;
  logic [3:0]                saved_level_q;
  logic [`VIP_NUM_TRAP-1:0]  trap_flag_q;
  logic [`VIP_FLAG_W-1:0]    request_flag_bank_q;
  logic [`VIP_FLAG_W-1:0]    enable_q;
  vip_prio_arr_t             prio_q;
  logic [6:0]                pending_vector_number_q;
  logic [3:0]                pending_new_level_q;
  logic [`VIP_EV_W-1:0]      ev_stat_q;
  logic [`VIP_EV_W-1:0]      ev_mask_q;
  logic [`VIP_EV_W-1:0]      ev_set_c;
  logic                      irq_q;
  logic                      req_q;
  logic [23:0]               vaddr_q;
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      setup_c;
  logic                      wr_c;
  logic                      prio_wr_c;
  logic                      go_c;
  logic [31:0]               rd_c;
  logic                      hit_c;
  logic [`VIP_FLAG_W-1:0]    flag_clr_c;
  logic [`VIP_WORDS-1:0]     en_sel_c;
  logic [`VIP_FLAG_W-1:0]    user_src_c;

  vip_arbiter u_arb (
    .arb (arb_bus)
  );

  assign setup_c   = psel_in && !penable_in;
  assign wr_c      = psel_in && penable_in && pready_q && pwrite_in;
  assign prio_wr_c = wr_c && (paddr_in[7:6] == `VIP_PRIO_SEL) && (paddr_in[5:2] < `VIP_PRIO_REGS);
  assign user_src_c = {{(`VIP_FLAG_W - `VIP_NUM_USER){1'b0}}, user_src_in};

  // only implemented positions can ever become pending.
  assign arb_bus.trap_pend = trap_flag_q & `VIP_TRAP_IMPL;
  assign arb_bus.user_pend = `VIP_NUM_USER'(request_flag_bank_q & enable_q);
  assign arb_bus.prio      = prio_q;

  // level gate: the winner must exceed the current CPU level.
  assign go_c = (state_q == VIP_IDLE) && arb_bus.win_valid &&
                (arb_bus.win_lvl > cpu_priority_level_q);

  always_comb begin
    flag_clr_c = '0;
    en_sel_c   = '0;
    for (int w = 0; w < `VIP_WORDS; w++) begin
      if (wr_c && paddr_in == `VIP_OFS_FLAG0 + 8'(4 * w)) begin
        flag_clr_c[`VIP_WORD_W*w +: `VIP_WORD_W] = pwdata_in;
      end
      if (wr_c && paddr_in == `VIP_OFS_EN0 + 8'(4 * w)) begin
        en_sel_c[w] = 1'b1;
      end
    end
  end

  always_comb begin
    rd_c  = 32'h0000_0000;
    hit_c = 1'b1;
    case (paddr_in)
      `VIP_OFS_CTRL2: rd_c[`VIP_ALT_BIT] = alt_table_select_q;
      `VIP_OFS_LEVEL: rd_c[3:0] = cpu_priority_level_q;
      `VIP_OFS_TRAPF: rd_c[`VIP_NUM_TRAP-1:0] = trap_flag_q;
      `VIP_OFS_PEND: begin
        rd_c[6:0] = pending_vector_number_q;
        rd_c[`VIP_PEND_LVL_LSB +: 4] = pending_new_level_q;
      end
      `VIP_OFS_STAT: rd_c[`VIP_EV_W-1:0] = ev_stat_q;
      `VIP_OFS_MASK: rd_c[`VIP_EV_W-1:0] = ev_mask_q;
      default: begin
        hit_c = 1'b0;
        for (int w = 0; w < `VIP_WORDS; w++) begin
          if (paddr_in == `VIP_OFS_FLAG0 + 8'(4 * w)) begin
            rd_c  = request_flag_bank_q[`VIP_WORD_W*w +: `VIP_WORD_W];
            hit_c = 1'b1;
          end
          if (paddr_in == `VIP_OFS_EN0 + 8'(4 * w)) begin
            rd_c  = enable_q[`VIP_WORD_W*w +: `VIP_WORD_W];
            hit_c = 1'b1;
          end
        end
        if (paddr_in[7:6] == `VIP_PRIO_SEL && paddr_in[5:2] < `VIP_PRIO_REGS &&
            paddr_in[1:0] == 2'b00) begin
          hit_c = 1'b1;
          for (int s = 0; s < `VIP_PRIO_PER_REG; s++) begin
            if (int'(paddr_in[5:2]) * `VIP_PRIO_PER_REG + s < `VIP_NUM_USER) begin
              rd_c[`VIP_PRIO_FLD_W*s +: 3] =
                prio_q[int'(paddr_in[5:2]) * `VIP_PRIO_PER_REG + s];
            end
          end
        end
      end
    endcase
  end

  // Zero-wait slave: answer is ready in the first access cycle.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_c;
      if (setup_c) begin
        prdata_q  <= pwrite_in ? 32'h0000_0000 : rd_c;
        pslverr_q <= !hit_c;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // alternate select and enable bits written by software.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      alt_table_select_q <= 1'b0;
      enable_q           <= '0;
      ev_mask_q          <= '0;
    end else begin
      if (wr_c && paddr_in == `VIP_OFS_CTRL2) begin
        alt_table_select_q <= pwdata_in[`VIP_ALT_BIT];
      end
      if (wr_c && paddr_in == `VIP_OFS_MASK) begin
        ev_mask_q <= pwdata_in[`VIP_EV_W-1:0];
      end
      for (int w = 0; w < `VIP_WORDS; w++) begin
        if (en_sel_c[w]) begin
          enable_q[`VIP_WORD_W*w +: `VIP_WORD_W] <= pwdata_in;
        end
      end
    end
  end

  // priority fields, three bits per source.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      prio_q <= '0;
    end else begin
      for (int s = 0; s < `VIP_NUM_USER; s++) begin
        if (prio_wr_c && int'(paddr_in[5:2]) == s / `VIP_PRIO_PER_REG) begin
          prio_q[s] <= pwdata_in[`VIP_PRIO_FLD_W*(s % `VIP_PRIO_PER_REG) +: 3];
        end
      end
    end
  end

  // sticky flags: a new request wins over a software clear.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      request_flag_bank_q <= '0;
      trap_flag_q         <= '0;
    end else begin
      request_flag_bank_q <= ((request_flag_bank_q & ~flag_clr_c) | user_src_c) &
                             `VIP_USER_IMPL;
      if (wr_c && paddr_in == `VIP_OFS_TRAPF) begin
        trap_flag_q <= ((trap_flag_q & ~pwdata_in[`VIP_NUM_TRAP-1:0]) | trap_src_in) &
                       `VIP_TRAP_IMPL;
      end else begin
        trap_flag_q <= (trap_flag_q | trap_src_in) & `VIP_TRAP_IMPL;
      end
    end
  end

  // fixed entry: request rises two edges after the go decision.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= VIP_IDLE;
    end else begin
      case (state_q)
        VIP_IDLE:   if (go_c) state_q <= VIP_LATCH;
        VIP_LATCH:  state_q <= VIP_REQ;
        VIP_REQ:    if (cpu_ack_in) state_q <= VIP_SERVE;
        VIP_SERVE:  if (cpu_return_in) state_q <= VIP_RETURN;
        VIP_RETURN: state_q <= VIP_IDLE;
        default:    state_q <= VIP_IDLE;
      endcase
    end
  end

  // latch vector number and new level on acceptance.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pending_vector_number_q <= 7'h00;
      pending_new_level_q     <= 4'h0;
    end else if (go_c) begin
      pending_vector_number_q <= arb_bus.win_vec;
      pending_new_level_q     <= arb_bus.win_lvl;
    end
  end

  // reset clears the dispatch address to the reset location.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vaddr_q <= `VIP_RESET_PC;
      req_q   <= 1'b0;
    end else begin
      if (state_q == VIP_LATCH) begin
        // address is base plus twice the vector number.
        // alternate table adds its fixed offset.
        vaddr_q <= `VIP_IVT_BASE + {16'h0000, pending_vector_number_q, 1'b0} +
                   (alt_table_select_q ? `VIP_ALTERNATE_VECTOR_TABLE_OFS : 24'h000000);
        // single request line to the core.
        req_q   <= 1'b1;
      end else if (state_q == VIP_REQ && cpu_ack_in) begin
        req_q <= 1'b0;
      end
    end
  end

  // software writes only the low three level bits.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cpu_priority_level_q <= 4'h0;
      saved_level_q        <= 4'h0;
    end else if (state_q == VIP_REQ && cpu_ack_in) begin
      saved_level_q        <= cpu_priority_level_q;
      cpu_priority_level_q <= pending_new_level_q;
    end else if (state_q == VIP_SERVE && cpu_return_in) begin
      cpu_priority_level_q <= saved_level_q;
    end else if (wr_c && paddr_in == `VIP_OFS_LEVEL) begin
      cpu_priority_level_q[`VIP_LVL_SW_W-1:0] <= pwdata_in[`VIP_LVL_SW_W-1:0];
    end
  end

  always_comb begin
    ev_set_c = '0;
    ev_set_c[`VIP_EV_USER] = (state_q == VIP_REQ) && cpu_ack_in && !pending_new_level_q[3];
    ev_set_c[`VIP_EV_TRAP] = (state_q == VIP_REQ) && cpu_ack_in && pending_new_level_q[3];
    ev_set_c[`VIP_EV_RET]  = (state_q == VIP_SERVE) && cpu_return_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ev_stat_q <= '0;
      irq_q     <= 1'b0;
    end else begin
      if (wr_c && paddr_in == `VIP_OFS_STAT) begin
        ev_stat_q <= (ev_stat_q & ~pwdata_in[`VIP_EV_W-1:0]) | ev_set_c;
      end else begin
        ev_stat_q <= ev_stat_q | ev_set_c;
      end
      irq_q <= |(ev_stat_q & ev_mask_q);
    end
  end

  assign prdata_out             = prdata_q;
  assign pready_out             = pready_q;
  assign pslverr_out            = pslverr_q;
  assign cpu_irq_req_out        = req_q;
  assign vector_addr_out        = vaddr_q;
  assign cpu_priority_level_out = cpu_priority_level_q;
  assign irq_out                = irq_q;

  a_entry_latency: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    go_c |-> ##1 !cpu_irq_req_out ##1 cpu_irq_req_out)
    else $error("Request did not rise two cycles after acceptance.");

  a_single_request: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    cpu_irq_req_out |-> state_q == VIP_REQ)
    else $error("Request line high outside the request state.");

  a_vector_latch: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    go_c |=> pending_vector_number_q == $past(arb_bus.win_vec) &&
             pending_new_level_q == $past(arb_bus.win_lvl))
    else $error("Vector number or level not latched on acceptance.");

  a_vector_address: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(cpu_irq_req_out) |-> vector_addr_out ==
      24'h000004 + {16'h0000, pending_vector_number_q, 1'b0} +
      (alt_table_select_q ? 24'h000100 : 24'h000000))
    else $error("Vector address does not match its table position.");

  a_level_gate: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (state_q == VIP_IDLE && arb_bus.win_lvl <= cpu_priority_level_q) |=>
      state_q == VIP_IDLE)
    else $error("Request forwarded at or below the CPU level.");

  a_trap_first: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    arb_bus.trap_pend[1] |-> arb_bus.win_vec == 7'h01 && arb_bus.win_lvl == 4'hE)
    else $error("Lowest trap position did not win arbitration.");

  a_flag_sticky: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (request_flag_bank_q[0] && !flag_clr_c[0]) |=> request_flag_bank_q[0])
    else $error("Request flag dropped without a software clear.");

  a_level_raise: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (state_q == VIP_REQ && cpu_ack_in) |=>
      cpu_priority_level_out == $past(pending_new_level_q))
    else $error("CPU level not raised to the accepted level.");

  a_return_restore: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (state_q == VIP_SERVE && cpu_return_in) |=>
      cpu_priority_level_q == $past(saved_level_q) ##1 state_q == VIP_IDLE)
    else $error("Return did not restore the level in fixed time.");

  a_top_bit_ro: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (state_q == VIP_IDLE && wr_c && paddr_in == `VIP_OFS_LEVEL) |=>
      cpu_priority_level_q[3] == $past(cpu_priority_level_q[3]))
    else $error("Software changed the read-only level bit.");

  a_irq_level: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (|(ev_stat_q & ev_mask_q)) |=> irq_out)
    else $error("Interrupt output low with an unmasked event set.");
endmodule // vip_controller

// >>> verification/vip_cpu_model.sv
`timescale 1ns/1ps
module vip_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        irq_req_in,
  input  wire logic [23:0] vec_addr_in,
  input  wire logic [3:0]  ack_wait_in,
  output logic             ack_out,
  output logic             ret_out,
  output logic      [23:0] handler_out
);
  localparam logic [23:0] DEF_HANDLER = 24'h000300;
  localparam logic [23:0] ISR_BASE    = 24'h000400;
  logic        busy_q;
  logic [7:0]  cnt_q;
  logic        used_c;
  logic [23:0] fetch_c;
  // table image: both tables share handlers, gaps get the default.
  assign used_c  = (vec_addr_in[23:9] == 15'h0000) &&
                   ((vec_addr_in[7:0] >= 8'h06 && vec_addr_in[7:0] <= 8'h0E) ||
                    vec_addr_in[7:0] >= 8'h14);
  assign fetch_c = used_c ? ISR_BASE + {16'h0000, vec_addr_in[7:0]} : DEF_HANDLER;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_out     <= 1'b0;
      ret_out     <= 1'b0;
      busy_q      <= 1'b0;
      cnt_q       <= 8'h00;
      handler_out <= 24'h000000;
    end else begin
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      if (!busy_q && irq_req_in && !ack_out) begin
        if (cnt_q == {4'h0, ack_wait_in}) begin
          ack_out     <= 1'b1;
          handler_out <= fetch_c;
          busy_q      <= 1'b1;
          cnt_q       <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end else if (busy_q) begin
        if (cnt_q == 8'h28) begin
          ret_out <= 1'b1;
          busy_q  <= 1'b0;
          cnt_q   <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // vip_cpu_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  trap;
  logic [79:0] usr;
  logic        ack;
  logic        ret;
  logic        req;
  logic        irq;
  logic [23:0] vaddr;
  logic [23:0] hnd;
  logic [3:0]  lvl;
  logic [3:0]  ack_wait;
  logic [31:0] rd;
  logic        serr;
  int          bad_count;
  int          check_count;
  int          lat;
  int          lat0;
  int          lat1;

  always #50 clk = ~clk;

  vip_controller u_vip_controller (
    .core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .trap_src_in(trap), .user_src_in(usr),
    .cpu_ack_in(ack), .cpu_return_in(ret), .cpu_irq_req_out(req),
    .vector_addr_out(vaddr), .cpu_priority_level_out(lvl), .irq_out(irq));

  vip_cpu_model u_vip_cpu_model (
    .clk_in(clk), .rst_in(rst), .irq_req_in(req), .vec_addr_in(vaddr),
    .ack_wait_in(ack_wait), .ack_out(ack), .ret_out(ret), .handler_out(hnd));

  task end_sim;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tmo;
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    end_sim();
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    if (pready !== 1'b1) tmo();
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input logic [7:0] t, input logic [79:0] u);
    @(posedge clk);
    trap <= t;
    usr  <= u;
    @(posedge clk);
    trap <= 8'h00;
    usr  <= 80'h0;
  endtask

  task quiet;
    repeat (20) begin
      @(posedge clk);
      chk(req, 32'h0);
    end
  endtask

  task serve(input logic [6:0] v, input logic [3:0] l, input logic alt);
    logic [3:0]  prev;
    logic [23:0] ea;
    int          n;
    prev = lvl;
    ea   = 24'h000004 + {16'h0, v, 1'b0} + (alt ? 24'h000100 : 24'h000000);
    for (lat = 0; lat < 60 && req !== 1'b1; lat++) @(posedge clk);
    if (req !== 1'b1) tmo();
    chk(vaddr, ea);
    for (n = 0; n < 40 && req === 1'b1; n++) @(posedge clk);
    chk(lvl, l);
    chk(hnd, 24'h000400 + {16'h0000, ea[7:0]});
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, {20'h0, l, 1'b0, v});
    apb(1'b1, 8'h08, 32'hFF);
    for (int i = 0; i < 3; i++) apb(1'b1, 8'h10 + 8'(4 * i), 32'hFFFFFFFF);
    for (n = 0; n < 100 && lvl !== prev; n++) @(posedge clk);
    chk(lvl, prev);
    repeat (3) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; trap = 8'h00; usr = 80'h0; ack_wait = 4'h0;
    bad_count = 0; check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(req, 32'h0);
    chk(vaddr, 32'h0);
    apb(1'b1, 8'h04, 32'hF);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 8'hFC, 32'h0);
    chk(serr, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    pulse(8'h02, 80'h0);
    serve(7'h01, 4'hE, 1'b0);
    lat0 = lat;
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h6);
    chk(irq, 32'h0);
    apb(1'b1, 8'h84, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    apb(1'b1, 8'h80, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, 8'h80, 32'h7);
    apb(1'b1, 8'h84, 32'h0);
    apb(1'b1, 8'h00, 32'h8000);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h8000);
    ack_wait <= 4'h5;
    pulse(8'h20, 80'h0);
    serve(7'h05, 4'hA, 1'b1);
    chk(lat, lat0);
    apb(1'b1, 8'h00, 32'h0);
    pulse(8'hC1, 80'h0);
    quiet();
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h1C, 32'h8007);
    for (int p = 1; p < 8; p++) begin
      apb(1'b1, 8'h40, 32'(p));
      ack_wait <= p[0] ? 4'h0 : 4'h3;
      pulse(8'h00, 80'h1);
      serve(7'h08, p[3:0], 1'b0);
      if (p == 1) lat1 = lat;
      chk(lat, lat1);
    end
    apb(1'b1, 8'h80, 32'h7);
    apb(1'b1, 8'h40, 32'h330);
    pulse(8'h00, 80'h6);
    serve(7'h09, 4'h3, 1'b0);
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, 8'h40, 32'h520);
    pulse(8'h00, 80'h6);
    serve(7'h0A, 4'h5, 1'b0);
    apb(1'b1, 8'h40, 32'h7);
    pulse(8'h04, 80'h1);
    serve(7'h02, 4'hD, 1'b0);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h40, 32'h3);
    pulse(8'h00, 80'h1);
    quiet();
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h40, 32'h4);
    serve(7'h08, 4'h4, 1'b0);
    apb(1'b1, 8'h04, 32'h7);
    apb(1'b1, 8'h40, 32'h7);
    pulse(8'h00, 80'h1);
    quiet();
    pulse(8'h08, 80'h0);
    serve(7'h03, 4'hC, 1'b0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h44, 32'h70000000);
    pulse(8'h00, 80'h8000);
    quiet();
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule // tb
